// ==== paged_i2c_regs.vh ====
`ifndef PAGED_I2C_REGS_VH
`define PAGED_I2C_REGS_VH

// ----------------------------------------
// Bus address
// ----------------------------------------
`define DEV_ADDR_FIXED 3'h5
`define STRAP_GND 2'h0
`define STRAP_SCL 2'h1
`define STRAP_SDA 2'h2
`define STRAP_VCC 2'h3

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define IRQ_ENABLE_MASK_OFS 8'hf0
`define IRQ_EVENT_FLAGS_OFS 8'hf1
`define PAGE_SELECT_OFS 8'hfd
`define PAGE_SELECT_UNLOCK_OFS 8'hfe

// ----------------------------------------
// Readable paged ranges
// ----------------------------------------
`define PAGE_ZERO 8'h00
`define PAGE_THREE 8'h03
`define OPEN_SHORT_FIRST 8'h18
`define OPEN_SHORT_LAST 8'h45
`define PAGE3_RESET_OFS 8'h11

// ----------------------------------------
// Fields
// ----------------------------------------
`define MASK_IRQ_AUTO_CLEAR_EN 3
`define MASK_BREATH_DONE_IRQ_EN 2
`define MASK_SHORT_IRQ_EN 1
`define MASK_OPEN_IRQ_EN 0
`define FLAG_BREATH_THREE 4
`define FLAG_BREATH_TWO 3
`define FLAG_BREATH_ONE 2
`define FLAG_SHORT 1
`define FLAG_OPEN 0
`define PAGE_UNLOCK_CODE 8'hc5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define IRQ_ENABLE_MASK_RST 4'h0
`define IRQ_EVENT_FLAGS_RST 5'h00
`define PAGE_SELECT_RST 8'h00
`define PAGE_SELECT_UNLOCK_RST 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define REF_CLK_HZ 125000000
`define IRQ_AUTO_CLEAR_MS 8
`define IRQ_AUTO_CLEAR_CYCLES (`IRQ_AUTO_CLEAR_MS * (`REF_CLK_HZ / 1000))

`endif

// ==== i2c_line_sampler.v ====
`timescale 1ns/1ps
`default_nettype none

module i2c_line_sampler (
  // Clock and reset
  input wire i_ref_clk,
  input wire i_reset_n,
  input wire i_clk_en,
  // Bus pins
  input wire i_scl,
  input wire i_sda,
  // Sampled line events
  output reg o_sda_q,
  output reg o_scl_rise_q,
  output reg o_scl_fall_q,
  output reg o_start_q,
  output reg o_stop_q
);

  reg scl_meta_q;
  reg sda_meta_q;
  reg scl_sync_q;
  reg sda_sync_q;
  reg scl_old_q;

  // ----------------------------------------
  // Two-stage synchronisers, then edge finding
  // ----------------------------------------
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      scl_meta_q <= 1'b1;
      sda_meta_q <= 1'b1;
      scl_sync_q <= 1'b1;
      sda_sync_q <= 1'b1;
      scl_old_q <= 1'b1;
      o_sda_q <= 1'b1;
      o_scl_rise_q <= 1'b0;
      o_scl_fall_q <= 1'b0;
      o_start_q <= 1'b0;
      o_stop_q <= 1'b0;
    end else if (i_clk_en) begin
      scl_meta_q <= i_scl;
      sda_meta_q <= i_sda;
      scl_sync_q <= scl_meta_q;
      sda_sync_q <= sda_meta_q;
      scl_old_q <= scl_sync_q;
      o_sda_q <= sda_sync_q;
      o_scl_rise_q <= scl_sync_q & ~scl_old_q;
      o_scl_fall_q <= ~scl_sync_q & scl_old_q;
      // SDA moving while SCL is high marks a frame boundary
      o_start_q <= scl_sync_q & scl_old_q & o_sda_q & ~sda_sync_q;
      o_stop_q <= scl_sync_q & scl_old_q & ~o_sda_q & sda_sync_q;
    end
  end

endmodule

`default_nettype wire

// ==== paged_i2c_register_port.v ====
// What this block does
// - Bus address upper bits fixed at 101
// - Straps give address bits 2:1 and 4:3
// - Direction bit 0 writes, 1 reads
// - SDA edges with SCL high: START, STOP
// - Address byte MSB first, acknowledged on match
// - Next write byte is register address, acknowledged
// - Data bytes MSB first, each acknowledged
// - Pointer increments at each data acknowledge
// - Only unlock, flags, open/short, reset readable
// - Read: write pointer, repeated START, read
// - Page select values 0..3 choose page
// - Page select powers up at page zero
// - Unlock code allows one page write
// - Unlock resets to zero, locked writes ignored
// - Write-only four-bit interrupt mask, reset clear
// - Auto-clear interrupt after 8ms low
// - Flags: breath three..one, short, open
`include "paged_i2c_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module paged_i2c_register_port #(
  parameter integer IRQ_AUTO_CLEAR_CYCLES = `IRQ_AUTO_CLEAR_CYCLES
) (
  // Clock, enable and reset
  input wire i_ref_clk,
  input wire i_reset_n,
  input wire i_clk_en,
  // Bus pins; SDA is open drain
  input wire i_scl,
  input wire i_sda,
  output reg o_sda_out,
  output reg o_sda_oe_n,
  // Address straps, decoded level per pin
  input wire [1:0] i_low_addr_strap,
  input wire [1:0] i_high_addr_strap,
  // Status events from the matrix core
  input wire i_breath_engine_one_done,
  input wire i_breath_engine_two_done,
  input wire i_breath_engine_three_done,
  input wire i_short_event,
  input wire i_open_event,
  // Paged register access toward the matrix core
  output reg [7:0] o_page,
  output reg [7:0] o_pg_addr,
  output reg [7:0] o_pg_wdata,
  output reg o_pg_wr_stb,
  input wire [7:0] i_pg_rdata,
  // Interrupt
  output reg o_irq_out_n
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_ADDR = 4'h1;
  localparam [3:0] S_ADDR_ACK = 4'h2;
  localparam [3:0] S_REG = 4'h3;
  localparam [3:0] S_REG_ACK = 4'h4;
  localparam [3:0] S_WDATA = 4'h5;
  localparam [3:0] S_WDATA_ACK = 4'h6;
  localparam [3:0] S_RDATA = 4'h7;
  localparam [3:0] S_RDATA_ACK = 4'h8;

  localparam [19:0] AUTO_CLR_LIMIT = IRQ_AUTO_CLEAR_CYCLES[19:0];

  wire sda_q;
  wire scl_rise;
  wire scl_fall;
  wire start_ev;
  wire stop_ev;

  reg [3:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg [7:0] ptr_q;
  reg master_ack_q;
  reg [1:0] low_meta_q;
  reg [1:0] low_sync_q;
  reg [1:0] high_meta_q;
  reg [1:0] high_sync_q;
  reg strap_taken_q;
  reg [6:0] dev_addr_q;
  reg [7:0] unlock_q;
  reg [3:0] mask_q;
  reg [4:0] flags_q;
  reg [19:0] low_cnt_q;
  reg flags_rd_clr;
  reg auto_clr;
  reg [4:0] flags_d;
  reg [4:0] events;
  reg irq_d;
  reg [7:0] tx_byte;

  // ----------------------------------------
  // Read-back decode
  // ----------------------------------------
  // Unreadable addresses return zero rather than stale data
  function [7:0] read_mux;
    input [7:0] addr;
    input [7:0] page;
    input [7:0] unlock;
    input [4:0] flags;
    input [7:0] pg_data;
    begin
      read_mux = 8'h00;
      if (addr == `PAGE_SELECT_UNLOCK_OFS) begin
        read_mux = unlock;
      end else if (addr == `IRQ_EVENT_FLAGS_OFS) begin
        read_mux = {3'h0, flags};
      end else if (page == `PAGE_ZERO && addr >= `OPEN_SHORT_FIRST &&
                   addr <= `OPEN_SHORT_LAST) begin
        read_mux = pg_data;
      end else if (page == `PAGE_THREE && addr == `PAGE3_RESET_OFS) begin
        read_mux = pg_data;
      end
    end
  endfunction

  // Pointer wraps at the top of the map; no guard, by choice
  function [7:0] ptr_next;
    input [7:0] ptr;
    begin
      ptr_next = ptr + 8'h01;
    end
  endfunction

  function [3:0] cnt_next;
    input [3:0] cnt;
    begin
      cnt_next = cnt + 4'h1;
    end
  endfunction

  i2c_line_sampler u_sampler (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_clk_en(i_clk_en),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_q(sda_q),
    .o_scl_rise_q(scl_rise),
    .o_scl_fall_q(scl_fall),
    .o_start_q(start_ev),
    .o_stop_q(stop_ev)
  );

  // ----------------------------------------
  // Strap capture after reset release
  // ----------------------------------------
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_meta_q <= 2'h0;
      low_sync_q <= 2'h0;
      high_meta_q <= 2'h0;
      high_sync_q <= 2'h0;
      strap_taken_q <= 1'b0;
      dev_addr_q <= 7'h00;
    end else if (i_clk_en) begin
      low_meta_q <= i_low_addr_strap;
      low_sync_q <= low_meta_q;
      high_meta_q <= i_high_addr_strap;
      high_sync_q <= high_meta_q;
      strap_taken_q <= 1'b1;
      // Straps are static; dev_addr_q recaptures every cycle once strap_taken_q is set
      if (strap_taken_q) begin
        dev_addr_q <= {`DEV_ADDR_FIXED, high_sync_q, low_sync_q};
      end
    end
  end

  always @* begin
    tx_byte = read_mux(ptr_q, o_page, unlock_q, flags_q, i_pg_rdata);
  end

  // ----------------------------------------
  // Bus protocol engine
  // ----------------------------------------
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= S_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ptr_q <= 8'h00;
      master_ack_q <= 1'b0;
      o_sda_out <= 1'b0;
      o_sda_oe_n <= 1'b1;
      o_page <= `PAGE_SELECT_RST;
      unlock_q <= `PAGE_SELECT_UNLOCK_RST;
      mask_q <= `IRQ_ENABLE_MASK_RST;
      o_pg_addr <= 8'h00;
      o_pg_wdata <= 8'h00;
      o_pg_wr_stb <= 1'b0;
      flags_rd_clr <= 1'b0;
    end else if (i_clk_en) begin
      o_pg_wr_stb <= 1'b0;
      flags_rd_clr <= 1'b0;
      o_pg_addr <= ptr_q;
      if (start_ev) begin
        state_q <= S_ADDR;
        bit_cnt_q <= 4'h0;
        o_sda_oe_n <= 1'b1;
      end else if (stop_ev) begin
        state_q <= S_IDLE;
        o_sda_oe_n <= 1'b1;
      end else begin
        case (state_q)
          S_ADDR, S_REG, S_WDATA: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_q};
              bit_cnt_q <= cnt_next(bit_cnt_q);
            end else if (scl_fall && bit_cnt_q == 4'h8) begin
              bit_cnt_q <= 4'h0;
              o_sda_oe_n <= 1'b0;
              if (state_q == S_ADDR) begin
                if (shift_q[7:1] == dev_addr_q) begin
                  master_ack_q <= shift_q[0];
                  state_q <= S_ADDR_ACK;
                end else begin
                  o_sda_oe_n <= 1'b1;
                  state_q <= S_IDLE;
                end
              end else if (state_q == S_REG) begin
                ptr_q <= shift_q;
                state_q <= S_REG_ACK;
              end else begin
                state_q <= S_WDATA_ACK;
                ptr_q <= ptr_next(ptr_q);
                case (ptr_q)
                  `IRQ_ENABLE_MASK_OFS: mask_q <= shift_q[3:0];
                  `IRQ_EVENT_FLAGS_OFS: mask_q <= mask_q;
                  `PAGE_SELECT_OFS: begin
                    // Locked writes are dropped so a stray byte cannot move pages
                    if (unlock_q == `PAGE_UNLOCK_CODE) begin
                      o_page <= shift_q;
                      unlock_q <= `PAGE_SELECT_UNLOCK_RST;
                    end
                  end
                  `PAGE_SELECT_UNLOCK_OFS: unlock_q <= shift_q;
                  default: begin
                    o_pg_wdata <= shift_q;
                    o_pg_wr_stb <= 1'b1;
                  end
                endcase
              end
            end
          end
          S_ADDR_ACK, S_REG_ACK, S_WDATA_ACK: begin
            if (scl_fall) begin
              bit_cnt_q <= 4'h0;
              o_sda_oe_n <= 1'b1;
              if (state_q == S_ADDR_ACK && master_ack_q) begin
                shift_q <= tx_byte;
                o_sda_oe_n <= tx_byte[7];
                flags_rd_clr <= (ptr_q == `IRQ_EVENT_FLAGS_OFS);
                state_q <= S_RDATA;
              end else if (state_q == S_ADDR_ACK) begin
                state_q <= S_REG;
              end else begin
                state_q <= S_WDATA;
              end
            end
          end
          S_RDATA: begin
            if (scl_fall) begin
              if (bit_cnt_q == 4'h7) begin
                o_sda_oe_n <= 1'b1;
                state_q <= S_RDATA_ACK;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                o_sda_oe_n <= shift_q[6];
                bit_cnt_q <= cnt_next(bit_cnt_q);
              end
            end
          end
          S_RDATA_ACK: begin
            if (scl_rise) begin
              master_ack_q <= ~sda_q;
              if (!sda_q) begin
                ptr_q <= ptr_next(ptr_q);
              end
            end else if (scl_fall) begin
              bit_cnt_q <= 4'h0;
              if (master_ack_q) begin
                shift_q <= tx_byte;
                o_sda_oe_n <= tx_byte[7];
                flags_rd_clr <= (ptr_q == `IRQ_EVENT_FLAGS_OFS);
                state_q <= S_RDATA;
              end else begin
                state_q <= S_IDLE;
              end
            end
          end
          default: begin
            o_sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Interrupt flags and output
  // ----------------------------------------
  always @* begin
    events = 5'h00;
    events[`FLAG_BREATH_THREE] = i_breath_engine_three_done;
    events[`FLAG_BREATH_TWO] = i_breath_engine_two_done;
    events[`FLAG_BREATH_ONE] = i_breath_engine_one_done;
    events[`FLAG_SHORT] = i_short_event;
    events[`FLAG_OPEN] = i_open_event;
    auto_clr = mask_q[`MASK_IRQ_AUTO_CLEAR_EN] && !o_irq_out_n &&
               (low_cnt_q > AUTO_CLR_LIMIT);
    // New events win over a clear in the same cycle
    flags_d = ((flags_rd_clr || auto_clr) ? 5'h00 : flags_q) | events;
    irq_d = ((flags_d[`FLAG_BREATH_THREE] | flags_d[`FLAG_BREATH_TWO] |
              flags_d[`FLAG_BREATH_ONE]) & mask_q[`MASK_BREATH_DONE_IRQ_EN]) |
            (flags_d[`FLAG_SHORT] & mask_q[`MASK_SHORT_IRQ_EN]) |
            (flags_d[`FLAG_OPEN] & mask_q[`MASK_OPEN_IRQ_EN]);
  end

  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flags_q <= `IRQ_EVENT_FLAGS_RST;
      o_irq_out_n <= 1'b1;
      low_cnt_q <= 20'h00000;
    end else if (i_clk_en) begin
      flags_q <= flags_d;
      o_irq_out_n <= ~irq_d;
      // Saturating so a long low never wraps back under the limit
      if (o_irq_out_n || auto_clr) begin
        low_cnt_q <= 20'h00000;
      end else if (low_cnt_q != 20'hfffff) begin
        low_cnt_q <= low_cnt_q + 20'h00001;
      end
    end
  end

endmodule

`default_nettype wire

// ==== i2c_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Bit-banged bus master
// ----------------------------------------
module i2c_host_model #(
  parameter integer HALF = 128
) (
  // Bus pins
  output var logic o_scl,
  output var logic o_sda_oe_n,
  input wire logic i_sda
);
  // Clock stands high between frames
  initial begin
    o_scl = 1'b1;
    o_sda_oe_n = 1'b1;
  end

  task automatic xfer(input logic b, output logic s);
    o_sda_oe_n = b;
    #(HALF / 2) o_scl = 1'b1;
    #(HALF) s = i_sda;
    o_scl = 1'b0;
    #(HALF / 2);
  endtask

  // Also serves as repeated START from a low clock
  task automatic start();
    o_sda_oe_n = 1'b1;
    #(HALF / 2) o_scl = 1'b1;
    #(HALF / 2) o_sda_oe_n = 1'b0;
    #(HALF / 2) o_scl = 1'b0;
    #(HALF / 2);
  endtask

  task automatic stop();
    o_sda_oe_n = 1'b0;
    #(HALF / 2) o_scl = 1'b1;
    #(HALF / 2) o_sda_oe_n = 1'b1;
    #(HALF);
  endtask

  // Released line on the ninth clock lets the device answer
  task automatic wr_byte(input logic [7:0] b, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) xfer(b[i], s);
    xfer(1'b1, ack_n);
  endtask

  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
    xfer(nack, s);
  endtask
endmodule

`default_nettype wire

// ==== paged_i2c_register_port_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module paged_i2c_port_checker #(
  parameter integer IRQ_AUTO_CLEAR_CYCLES = 50
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Bus and events
  input wire logic i_scl,
  input wire logic i_breath_engine_one_done,
  input wire logic i_breath_engine_two_done,
  input wire logic i_breath_engine_three_done,
  input wire logic i_short_event,
  input wire logic i_open_event,
  // Outputs watched
  input wire logic o_sda_out,
  input wire logic o_sda_oe_n,
  input wire logic [7:0] o_page,
  input wire logic [7:0] o_pg_addr,
  input wire logic o_pg_wr_stb,
  input wire logic o_irq_out_n
);
  int low_cnt_q;
  logic [7:0] stb_addr_q;
  wire logic ev_any = i_breath_engine_one_done | i_breath_engine_two_done |
    i_breath_engine_three_done | i_short_event | i_open_event;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      low_cnt_q <= 0;
      stb_addr_q <= 8'h00;
    end else begin
      low_cnt_q <= o_irq_out_n ? 0 : low_cnt_q + 1;
      if (o_pg_wr_stb) stb_addr_q <= o_pg_addr;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  sda_only_low_a: assert property (!o_sda_out)
    else $error("sda driven high");
  sda_change_low_a: assert property ($changed(o_sda_oe_n) |-> !i_scl)
    else $error("sda changed while scl high");
  stb_single_a: assert property (o_pg_wr_stb |=> !o_pg_wr_stb)
    else $error("write strobe too long");
  wr_on_low_a: assert property (o_pg_wr_stb |-> !i_scl)
    else $error("write strobe with scl high");
  ptr_step_a: assert property ($past(o_pg_wr_stb) |-> ##[0:60] o_pg_addr == stb_addr_q + 8'h01)
    else $error("pointer did not step");
  page_quiet_a: assert property (i_scl [*8] |-> $stable(o_page))
    else $error("page changed on idle bus");
  irq_set_cause_a: assert property ($fell(o_irq_out_n) |-> $past(ev_any) || !i_scl)
    else $error("interrupt without event");
  irq_clear_cause_a: assert property ($rose(o_irq_out_n) |-> !i_scl || low_cnt_q >= IRQ_AUTO_CLEAR_CYCLES)
    else $error("interrupt released early");
  reset_values_a: assert property ($rose(i_reset_n) |-> o_page == 8'h00 && o_irq_out_n)
    else $error("bad value after reset");

  cover property (o_pg_wr_stb);
  cover property ($fell(o_irq_out_n));
  cover property ($fell(o_sda_oe_n));
  cover property ($changed(o_page));
endmodule

bind paged_i2c_register_port paged_i2c_port_checker #(
  .IRQ_AUTO_CLEAR_CYCLES(IRQ_AUTO_CLEAR_CYCLES)
) chk (
  .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_scl(i_scl),
  .i_breath_engine_one_done(i_breath_engine_one_done),
  .i_breath_engine_two_done(i_breath_engine_two_done),
  .i_breath_engine_three_done(i_breath_engine_three_done),
  .i_short_event(i_short_event), .i_open_event(i_open_event),
  .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n), .o_page(o_page),
  .o_pg_addr(o_pg_addr), .o_pg_wr_stb(o_pg_wr_stb), .o_irq_out_n(o_irq_out_n)
);

`default_nettype wire

// ==== paged_i2c_register_port_tb.sv ====
`include "paged_i2c_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module paged_i2c_register_port_tb;
  // Short auto-clear keeps the run brief
  localparam integer ACP = 50;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic host_oe_n, scl, sda, dut_sda_out, dut_oe_n, stb, irq_n, ack_n;
  logic [1:0] lo_strap = 2'h0;
  logic [1:0] hi_strap = 2'h0;
  logic [4:0] ev = 5'h00;
  logic [7:0] page, pg_addr, pg_wdata, pg_rdata, rnd, exp_pg;
  logic [6:0] dev;
  logic [23:0] wq[$];
  logic [23:0] exp_w;
  int fail_count = 0;
  int compares = 0;
  int seed = 32'hbb85d116;

  always #4 clk = ~clk;
  // Open-drain wire with pull-up
  assign sda = (!host_oe_n || (!dut_oe_n && !dut_sda_out)) ? 1'b0 : 1'b1;
  assign pg_rdata = pg_addr ^ page ^ 8'h5a;

  i2c_host_model #(.HALF(128)) host (.o_scl(scl), .o_sda_oe_n(host_oe_n), .i_sda(sda));

  paged_i2c_register_port #(.IRQ_AUTO_CLEAR_CYCLES(ACP)) dut (
    .i_ref_clk(clk), .i_reset_n(rst_n), .i_clk_en(clk_en), .i_scl(scl), .i_sda(sda),
    .o_sda_out(dut_sda_out), .o_sda_oe_n(dut_oe_n),
    .i_low_addr_strap(lo_strap), .i_high_addr_strap(hi_strap),
    .i_breath_engine_one_done(ev[2]), .i_breath_engine_two_done(ev[3]),
    .i_breath_engine_three_done(ev[4]), .i_short_event(ev[1]), .i_open_event(ev[0]),
    .o_page(page), .o_pg_addr(pg_addr), .o_pg_wdata(pg_wdata), .o_pg_wr_stb(stb),
    .i_pg_rdata(pg_rdata), .o_irq_out_n(irq_n)
  );

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_wr(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Empty queue gives an unknown note, so a stray strobe fails
  // Falling edge keeps the look clear of the edge that launches the strobe
  always @(negedge clk) begin
    if (stb === 1'b1) begin
      exp_w = (wq.size() > 0) ? wq.pop_front() : 24'hxxxxxx;
      chk_wr({page, pg_addr, pg_wdata}, exp_w);
    end
  end

  task automatic tally_and_finish();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    tick(6);
    rst_n = 1'b1;
    tick(12);
    chk(page, 8'h00);
    chk({7'h0, irq_n}, 8'h01);
  endtask

  task automatic pulse(input logic [4:0] v);
    ev = v;
    tick(1);
    ev = 5'h00;
    tick(2);
  endtask

  task automatic head(input logic [7:0] ra);
    host.start();
    host.wr_byte({dev, 1'b0}, ack_n);
    chk({7'h0, ack_n}, 8'h00);
    host.wr_byte(ra, ack_n);
    chk({7'h0, ack_n}, 8'h00);
  endtask

  task automatic wr(input logic [7:0] ra, input logic [7:0] d, input int n);
    head(ra);
    for (int i = 0; i < n; i++) begin
      if (ra < 8'hf0) wq.push_back({exp_pg, ra + i[7:0], d + i[7:0]});
      host.wr_byte(d + i[7:0], ack_n);
      chk({7'h0, ack_n}, 8'h00);
    end
    host.stop();
  endtask

  task automatic rd(input logic [7:0] ra, input int n, input logic [7:0] e0);
    logic [7:0] b;
    head(ra);
    host.start();
    host.wr_byte({dev, 1'b1}, ack_n);
    chk({7'h0, ack_n}, 8'h00);
    for (int i = 0; i < n; i++) begin
      host.rd_byte(i == n - 1, b);
      chk(b, e0 + i[7:0]);
    end
    host.stop();
  endtask

  initial begin
    do_reset();
    for (int s = 0; s < 16; s++) begin
      {hi_strap, lo_strap} = s[3:0];
      do_reset();
      dev = {3'b101, s[3:0]};
      host.start();
      host.wr_byte({dev, 1'b0}, ack_n);
      chk({7'h0, ack_n}, 8'h00);
      host.stop();
      host.start();
      host.wr_byte({dev ^ (7'h01 << (s % 7)), 1'b0}, ack_n);
      chk({7'h0, ack_n}, 8'h01);
      host.stop();
    end
    $display("test address straps done");
    wr(`PAGE_SELECT_OFS, 8'h02, 1);
    chk(page, 8'h00);
    rd(`PAGE_SELECT_UNLOCK_OFS, 1, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr(`PAGE_SELECT_UNLOCK_OFS, `PAGE_UNLOCK_CODE, 1);
      rd(`PAGE_SELECT_UNLOCK_OFS, 1, `PAGE_UNLOCK_CODE);
      wr(`PAGE_SELECT_OFS, p[7:0], 1);
      chk(page, p[7:0]);
      rd(`PAGE_SELECT_UNLOCK_OFS, 1, 8'h00);
      exp_pg = p[7:0];
      rnd = $random(seed);
      wr(8'h10, rnd, 3);
    end
    wr(`PAGE_SELECT_OFS, 8'h01, 1);
    chk(page, 8'h03);
    rd(`PAGE3_RESET_OFS, 1, 8'h11 ^ 8'h03 ^ 8'h5a);
    rd(8'h20, 1, 8'h00);
    wr(`PAGE_SELECT_UNLOCK_OFS, `PAGE_UNLOCK_CODE, 1);
    wr(`PAGE_SELECT_OFS, `PAGE_ZERO, 1);
    rd(`OPEN_SHORT_FIRST, 2, 8'h18 ^ 8'h5a);
    rd(`OPEN_SHORT_LAST, 1, 8'h45 ^ 8'h5a);
    rd(8'h46, 1, 8'h00);
    $display("test paging done");
    pulse(5'h1f);
    chk({7'h0, irq_n}, 8'h01);
    rd(`IRQ_EVENT_FLAGS_OFS, 1, 8'h1f);
    wr(`IRQ_ENABLE_MASK_OFS, 8'h02, 1);
    pulse(5'h01);
    chk({7'h0, irq_n}, 8'h01);
    pulse(5'h02);
    chk({7'h0, irq_n}, 8'h00);
    rd(`IRQ_EVENT_FLAGS_OFS, 1, 8'h03);
    chk({7'h0, irq_n}, 8'h01);
    wr(`IRQ_ENABLE_MASK_OFS, 8'h04, 1);
    pulse(5'h14);
    tick(3 * ACP);
    chk({7'h0, irq_n}, 8'h00);
    rd(`IRQ_EVENT_FLAGS_OFS, 1, 8'h14);
    wr(`IRQ_ENABLE_MASK_OFS, 8'h0c, 1);
    pulse(5'h08);
    tick(ACP - 10);
    chk({7'h0, irq_n}, 8'h00);
    tick(20);
    chk({7'h0, irq_n}, 8'h01);
    // Events while the enable is low must leave no trace
    clk_en = 1'b0;
    pulse(5'h1f);
    clk_en = 1'b1;
    tick(2);
    chk({7'h0, irq_n}, 8'h01);
    rd(`IRQ_EVENT_FLAGS_OFS, 1, 8'h00);
    $display("test interrupts done");
    chk(8'(wq.size()), 8'h00);
    tally_and_finish();
  end

  // Run needs about 440 us; the 700 us limit sits about 260 us above it
  initial begin
    #700000;
    fail_count++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
